//--- vic_pkg.sv
// Constants, types and the vector table shared by the interrupt controller
package vic_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_SRC = 22;
	localparam int IDX_W = 5;
	localparam int VEC_W = 16;
	localparam int NUM_RST = 4;

	// ------------------------------------------------------------
	// Vector table addresses
	// ------------------------------------------------------------
	localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
	localparam logic [VEC_W-1:0] BREAK_VECTOR = 16'h003E;
	// Entry n belongs to request index n, index 0 the highest default priority
	localparam logic [VEC_W-1:0] VECTOR_TABLE [0:NUM_SRC-1] = '{
		16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E,
		16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A,
		16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0024, 16'h0026,
		16'h0028, 16'h002A, 16'h002E, 16'h0034
	};

	// ------------------------------------------------------------
	// Request index of each source
	// ------------------------------------------------------------
	localparam int IDX_LOW_VOLTAGE = 0;
	localparam int IDX_EXT_PIN_0 = 1;
	localparam int IDX_UART_B_RX_ERROR = 7;
	localparam int IDX_UART_B_RX_DONE = 8;
	localparam int IDX_UART_B_TX_DONE = 9;
	localparam int IDX_SERIAL_SHARED = 10;
	localparam int IDX_TIMER_H_UNIT1 = 11;
	localparam int IDX_TIMER_H_UNIT0 = 12;
	localparam int IDX_EVENT_COUNTER_50 = 13;
	localparam int IDX_WIDE_TIMER_CH0 = 14;
	localparam int IDX_WIDE_TIMER_CH1 = 15;
	localparam int IDX_ADC_DONE = 16;
	localparam int IDX_UART_A_RX = 17;
	localparam int IDX_WATCH_INTERVAL = 18;
	localparam int IDX_EVENT_COUNTER_51 = 19;
	localparam int IDX_WATCH_OVERFLOW = 20;
	localparam int IDX_SERIAL_BUS_DONE = 21;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic low_voltage_irq;
		logic [5:0] ext_pin_irq;
		logic uart_b_rx_error_irq;
		logic uart_b_rx_done_irq;
		logic uart_b_tx_done_irq;
		logic clocked_serial_done_irq;
		logic uart_a_tx_done_irq;
		logic timer_h_unit1_irq;
		logic timer_h_unit0_irq;
		logic event_counter_50_irq;
		logic wide_timer_ch0_irq;
		logic wide_timer_ch1_irq;
		logic adc_done_irq;
		logic uart_a_rx_irq;
		logic watch_interval_irq;
		logic event_counter_51_irq;
		logic watch_overflow_irq;
		logic serial_bus_done_irq;
	} irq_src_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_OFFER = 2'b10
	} vic_state_t;

	typedef struct packed {
		vic_state_t fsm;
		logic [NUM_SRC-1:0] pending;
		logic brk_pending;
		logic [IDX_W-1:0] sel_idx;
		logic sel_brk;
		logic isp_high;
		logic isp_low;
		logic irq_req;
		logic [VEC_W-1:0] vector;
		logic standby;
		logic reset_req;
	} vic_regs_t;

endpackage : vic_pkg

//--- vectored_interrupt_control.sv
// Vectored interrupt controller: request latching, grouping, arbitration, vectors
// How it works
// - Priority flag puts each source high or low
// - High request may nest over low service
// - Same group resolved by fixed index order
// - Unmasked request raises standby release
// - Break accepted even with interrupts disabled
// - Break ignores groups and in-service flags
// - Four reset sources share one vector
// - Low-voltage request: priority 0, vector 0004
// - Pin edges: priorities 1-6, vectors 0006-0010
// - UART B error: priority 7, vector 0012
// - UART B receive: priority 8, vector 0014
// - UART B transmit: priority 9, vector 0016
// - Serial port, UART A transmit share 0018
// - Timer H unit 1: priority 11, 001A
// - Timer H unit 0: priority 12, 001C
// - Event counter 50: priority 13, 001E
// - Wide timer channel 0: priority 14, 0020
// - Wide timer channel 1: priority 15, 0022
// - A/D done: priority 16, vector 0024
// - UART A receive or error: 17, 0026
// - Watch interval: priority 18, vector 0028
// - Event counter 51: priority 19, 002A
// - Priority 0 highest down to 21 lowest
// - Watch overflow 002E, serial bus 0034
// - Break vector 003E, resets vector 0000
`timescale 1ns/1ps

module vectored_interrupt_control (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire vic_pkg::irq_src_t irq_src_in,
	input wire logic [vic_pkg::NUM_SRC-1:0] mask_flags_in,
	input wire logic [vic_pkg::NUM_SRC-1:0] priority_flags_in,
	input wire logic int_enable_in,
	input wire logic break_instruction_in,
	input wire logic [vic_pkg::NUM_RST-1:0] reset_src_in,
	input wire logic cpu_ack_in,
	input wire logic cpu_return_in,
	output logic irq_req_out,
	output logic irq_is_break_out,
	output logic [vic_pkg::VEC_W-1:0] vector_out,
	output logic in_service_high_out,
	output logic in_service_low_out,
	output logic [vic_pkg::NUM_SRC-1:0] pending_out,
	output logic standby_release_out,
	output logic reset_req_out
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------

	// Lowest set index wins, which is the highest default priority
	function automatic logic [vic_pkg::IDX_W-1:0] first_set(
		input logic [vic_pkg::NUM_SRC-1:0] vec
	);
		logic [vic_pkg::IDX_W-1:0] idx;
		idx = 5'h00;
		for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (vec[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction : first_set

	function automatic logic [vic_pkg::VEC_W-1:0] vector_of(
		input logic [vic_pkg::IDX_W-1:0] idx
	);
		return vic_pkg::VECTOR_TABLE[idx];
	endfunction : vector_of

	// Map each peripheral line onto its request index
	function automatic logic [vic_pkg::NUM_SRC-1:0] pack_requests(
		input vic_pkg::irq_src_t s
	);
		logic [vic_pkg::NUM_SRC-1:0] v;
		v = 22'h00_0000;
		v[vic_pkg::IDX_LOW_VOLTAGE] = s.low_voltage_irq;
		for (int p = 0; p < 6; p++) begin
			v[vic_pkg::IDX_EXT_PIN_0 + p] = s.ext_pin_irq[p];
		end
		v[vic_pkg::IDX_UART_B_RX_ERROR] = s.uart_b_rx_error_irq;
		v[vic_pkg::IDX_UART_B_RX_DONE] = s.uart_b_rx_done_irq;
		v[vic_pkg::IDX_UART_B_TX_DONE] = s.uart_b_tx_done_irq;
		// Either event sets the same flag; software tells them apart
		v[vic_pkg::IDX_SERIAL_SHARED] = s.clocked_serial_done_irq
			| s.uart_a_tx_done_irq;
		v[vic_pkg::IDX_TIMER_H_UNIT1] = s.timer_h_unit1_irq;
		v[vic_pkg::IDX_TIMER_H_UNIT0] = s.timer_h_unit0_irq;
		v[vic_pkg::IDX_EVENT_COUNTER_50] = s.event_counter_50_irq;
		// Timer already merges compare match and capture edge per channel
		v[vic_pkg::IDX_WIDE_TIMER_CH0] = s.wide_timer_ch0_irq;
		v[vic_pkg::IDX_WIDE_TIMER_CH1] = s.wide_timer_ch1_irq;
		v[vic_pkg::IDX_ADC_DONE] = s.adc_done_irq;
		v[vic_pkg::IDX_UART_A_RX] = s.uart_a_rx_irq;
		v[vic_pkg::IDX_WATCH_INTERVAL] = s.watch_interval_irq;
		v[vic_pkg::IDX_EVENT_COUNTER_51] = s.event_counter_51_irq;
		v[vic_pkg::IDX_WATCH_OVERFLOW] = s.watch_overflow_irq;
		v[vic_pkg::IDX_SERIAL_BUS_DONE] = s.serial_bus_done_irq;
		return v;
	endfunction : pack_requests

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	vic_pkg::vic_regs_t state_reg;
	vic_pkg::vic_regs_t state_next;

	logic [vic_pkg::NUM_SRC-1:0] req_set;
	logic [vic_pkg::NUM_SRC-1:0] req_clr;
	logic [vic_pkg::NUM_SRC-1:0] eligible;
	logic [vic_pkg::NUM_SRC-1:0] group_high;
	logic [vic_pkg::NUM_SRC-1:0] group_low;
	logic [vic_pkg::NUM_SRC-1:0] candidates;
	logic allow_high;
	logic allow_low;
	logic brk_clr;
	logic isp_high_after_ret;
	logic isp_low_after_ret;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		req_set = pack_requests(irq_src_in);
		req_clr = 22'h00_0000;
		brk_clr = 1'b0;

		eligible = state_reg.pending & ~mask_flags_in;
		// Flag clear selects the high group, set selects the low group
		group_high = eligible & ~priority_flags_in;
		group_low = eligible & priority_flags_in;

		// Low service never blocks a high request, only high service does
		allow_high = int_enable_in & ~state_reg.isp_high;
		allow_low = int_enable_in & ~state_reg.isp_high & ~state_reg.isp_low;

		if (allow_high && (|group_high)) begin
			candidates = group_high;
		end else if (allow_low) begin
			candidates = group_low;
		end else begin
			candidates = 22'h00_0000;
		end

		// Return pops the innermost level first
		isp_high_after_ret = state_reg.isp_high;
		isp_low_after_ret = state_reg.isp_low;
		if (cpu_return_in) begin
			if (state_reg.isp_high) begin
				isp_high_after_ret = 1'b0;
			end else begin
				isp_low_after_ret = 1'b0;
			end
		end
		state_next.isp_high = isp_high_after_ret;
		state_next.isp_low = isp_low_after_ret;

		unique case (state_reg.fsm)
			vic_pkg::ST_IDLE: begin
				// Break outranks every maskable request and needs no enable
				if (state_reg.brk_pending) begin
					state_next.sel_brk = 1'b1;
					state_next.fsm = vic_pkg::ST_OFFER;
				end else if (|candidates) begin
					state_next.sel_brk = 1'b0;
					state_next.sel_idx = first_set(candidates);
					state_next.fsm = vic_pkg::ST_OFFER;
				end
			end
			vic_pkg::ST_OFFER: begin
				if (cpu_ack_in) begin
					state_next.fsm = vic_pkg::ST_IDLE;
					if (state_reg.sel_brk) begin
						brk_clr = 1'b1;
					end else begin
						req_clr[state_reg.sel_idx] = 1'b1;
						if (priority_flags_in[state_reg.sel_idx]) begin
							state_next.isp_low = 1'b1;
						end else begin
							state_next.isp_high = 1'b1;
						end
					end
				end else if (!state_reg.sel_brk && !candidates[state_reg.sel_idx]) begin
					// Masked or disabled while offered: withdraw and re-arbitrate
					state_next.fsm = vic_pkg::ST_IDLE;
				end
			end
		endcase

		// A new event in the clearing cycle stays pending
		state_next.pending = (state_reg.pending & ~req_clr) | req_set;
		state_next.brk_pending = (state_reg.brk_pending & ~brk_clr)
			| break_instruction_in;

		// Wake-up ignores the global enable and the in-service flags
		state_next.standby = |eligible;

		state_next.reset_req = |reset_src_in;

		if (state_next.reset_req) begin
			state_next.irq_req = 1'b0;
			state_next.vector = vic_pkg::RESET_VECTOR;
		end else if (state_next.fsm == vic_pkg::ST_OFFER) begin
			state_next.irq_req = 1'b1;
			if (state_next.sel_brk) begin
				state_next.vector = vic_pkg::BREAK_VECTOR;
			end else begin
				state_next.vector = vector_of(state_next.sel_idx);
			end
		end else begin
			state_next.irq_req = 1'b0;
			state_next.vector = state_reg.vector;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg.fsm <= vic_pkg::ST_IDLE;
			state_reg.pending <= 22'h00_0000;
			state_reg.brk_pending <= 1'b0;
			state_reg.sel_idx <= 5'h00;
			state_reg.sel_brk <= 1'b0;
			state_reg.isp_high <= 1'b0;
			state_reg.isp_low <= 1'b0;
			state_reg.irq_req <= 1'b0;
			state_reg.vector <= vic_pkg::RESET_VECTOR;
			state_reg.standby <= 1'b0;
			state_reg.reset_req <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign irq_req_out = state_reg.irq_req;
	assign irq_is_break_out = state_reg.sel_brk;
	assign vector_out = state_reg.vector;
	assign in_service_high_out = state_reg.isp_high;
	assign in_service_low_out = state_reg.isp_low;
	assign pending_out = state_reg.pending;
	assign standby_release_out = state_reg.standby;
	assign reset_req_out = state_reg.reset_req;

endmodule : vectored_interrupt_control

//--- vic_checker_properties.sv
// Concurrent checks on the ports of the vectored interrupt controller
`timescale 1ns/1ps
module vic_checker (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire vic_pkg::irq_src_t irq_src_in,
	input wire logic [vic_pkg::NUM_SRC-1:0] mask_flags_in,
	input wire logic break_instruction_in,
	input wire logic [vic_pkg::NUM_RST-1:0] reset_src_in,
	input wire logic cpu_ack_in,
	input wire logic cpu_return_in,
	input wire logic irq_req_out,
	input wire logic irq_is_break_out,
	input wire logic [vic_pkg::VEC_W-1:0] vector_out,
	input wire logic in_service_high_out,
	input wire logic in_service_low_out,
	input wire logic [vic_pkg::NUM_SRC-1:0] pending_out,
	input wire logic standby_release_out,
	input wire logic reset_req_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	property p_pend_set;
		irq_src_in.low_voltage_irq |=> pending_out[0];
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("pending flag not set");
	property p_pend_keep;
		(($past(pending_out) & ~pending_out) != '0) |-> $past(irq_req_out) && $past(cpu_ack_in);
	endproperty
	a_pend_keep: assert property (p_pend_keep) else $error("pending lost without ack");
	property p_stby;
		|(pending_out & ~mask_flags_in) |=> standby_release_out;
	endproperty
	a_stby: assert property (p_stby) else $error("no standby release");
	property p_brk;
		break_instruction_in ##1 (!irq_req_out && reset_src_in == '0)
			|=> irq_req_out && irq_is_break_out && vector_out == 16'h003E;
	endproperty
	a_brk: assert property (p_brk) else $error("break not offered");
	property p_rst;
		|reset_src_in |=> reset_req_out && vector_out == 16'h0000 && !irq_req_out;
	endproperty
	a_rst: assert property (p_rst) else $error("reset vector wrong");
	property p_ack;
		irq_req_out && cpu_ack_in && !irq_is_break_out
			|=> !irq_req_out && (in_service_high_out || in_service_low_out);
	endproperty
	a_ack: assert property (p_ack) else $error("ack not taken");
	property p_brk_isp;
		irq_req_out && irq_is_break_out && cpu_ack_in && !cpu_return_in
			|=> $stable(in_service_high_out) && $stable(in_service_low_out);
	endproperty
	a_brk_isp: assert property (p_brk_isp) else $error("break touched in-service");
	property p_ret;
		cpu_return_in && in_service_high_out && !cpu_ack_in |=> !in_service_high_out;
	endproperty
	a_ret: assert property (p_ret) else $error("return did not pop");
	property p_vec;
		irq_req_out && !irq_is_break_out |-> !vector_out[0]
			&& (vector_out inside {[16'h0004:16'h002A]} || vector_out inside {16'h002E, 16'h0034});
	endproperty
	a_vec: assert property (p_vec) else $error("vector out of table");
endmodule : vic_checker
bind vectored_interrupt_control vic_checker i_checker (.*);

//--- cpu_side_model.sv
// CPU side model: takes an offered vector after a set lag
`timescale 1ns/1ps
module cpu_side_model (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic irq_req_in,
	input wire logic [3:0] lag_in,
	output logic ack_out
);
	logic [3:0] wait_reg;
	// Lag lets the offer stand a while; a withdrawn offer restarts the count
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wait_reg <= 4'h0;
			ack_out <= 1'b0;
		end else begin
			ack_out <= irq_req_in && !ack_out && wait_reg == lag_in;
			wait_reg <= (irq_req_in && !ack_out && wait_reg != lag_in) ? wait_reg + 4'h1 : 4'h0;
		end
	end
endmodule : cpu_side_model

//--- vectored_interrupt_control_bench.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vectored_interrupt_control_bench;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	vic_pkg::irq_src_t src = '0;
	logic [21:0] mask = '0;
	logic [21:0] prio = '0;
	logic enable = 1'b1;
	logic break_instruction = 1'b0;
	logic [3:0] rsrc = '0;
	logic ret = 1'b0;
	logic [3:0] lag = 4'h2;
	logic ack, irq, is_brk, ish, isl, stby, rreq;
	logic [15:0] vec;
	logic [21:0] pend;
	int bad_count = 0;
	int checked = 0;
	always #20 mclk_in = ~mclk_in;
	vectored_interrupt_control i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .irq_src_in(src),
		.mask_flags_in(mask), .priority_flags_in(prio), .int_enable_in(enable),
		.break_instruction_in(break_instruction), .reset_src_in(rsrc), .cpu_ack_in(ack), .cpu_return_in(ret),
		.irq_req_out(irq), .irq_is_break_out(is_brk), .vector_out(vec),
		.in_service_high_out(ish), .in_service_low_out(isl), .pending_out(pend),
		.standby_release_out(stby), .reset_req_out(rreq));
	cpu_side_model i_cpu (.mclk_in(mclk_in), .rst_in(rst_in), .irq_req_in(irq), .lag_in(lag),
		.ack_out(ack));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task summarize;
		$display("counts checked=%0d bad=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic vic_pkg::irq_src_t src_of(input int i, input logic alt);
		vic_pkg::irq_src_t s;
		s = '0;
		if (i == 0) s[22] = 1'b1;
		else if (i < 7) s[15 + i] = 1'b1;
		else if (i < 11) s[alt ? 11 : 22 - i] = 1'b1;
		else s[21 - i] = 1'b1;
		return s;
	endfunction : src_of
	function automatic logic [15:0] ev(input int i);
		if (i < 20) return 16'(4 + 2 * i);
		return (i == 20) ? 16'h002E : 16'h0034;
	endfunction : ev
	task pulse(input vic_pkg::irq_src_t s, input logic b);
		@(posedge mclk_in);
		src <= s;
		break_instruction <= b;
		@(posedge mclk_in);
		src <= '0;
		break_instruction <= 1'b0;
	endtask : pulse
	task give_back;
		@(posedge mclk_in);
		ret <= 1'b1;
		@(posedge mclk_in);
		ret <= 1'b0;
	endtask : give_back
	// Bounded wait for an offer, then for the model to take it
	task offer(input logic [15:0] exp_vec, input logic exp_brk);
		int n;
		// Never read outputs in the time step of the edge that launches them
		@(negedge mclk_in);
		for (n = 0; n < 24 && irq !== 1'b1; n++) @(negedge mclk_in);
		if (n == 24) begin
			bad_count++;
			summarize();
		end
		chk(vec, exp_vec);
		chk(16'(is_brk), 16'(exp_brk));
		for (n = 0; n < 24 && irq !== 1'b0; n++) @(negedge mclk_in);
		if (n == 24) begin
			bad_count++;
			summarize();
		end
		chk(16'(irq), 16'h0000);
	endtask : offer
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_table;
		for (int i = 0; i < 23; i++) begin
			lag <= (i % 2 == 0) ? 4'h0 : 4'h9;
			pulse(src_of(i == 22 ? 10 : i, i == 22), 1'b0);
			offer(ev(i == 22 ? 10 : i), 1'b0);
			chk(16'(ish), 16'h0001);
			give_back();
		end
		$display("test table done");
	endtask : t_table
	task t_order;
		pulse(src_of(17, 1'b0) | src_of(3, 1'b0), 1'b0);
		offer(ev(3), 1'b0);
		give_back();
		offer(ev(17), 1'b0);
		give_back();
		$display("test order done");
	endtask : t_order
	task t_nest;
		@(posedge mclk_in);
		prio <= 22'h0A_0000;
		pulse(src_of(17, 1'b0), 1'b0);
		offer(ev(17), 1'b0);
		chk(16'(isl), 16'h0001);
		pulse(src_of(5, 1'b0), 1'b0);
		offer(ev(5), 1'b0);
		chk(16'(ish), 16'h0001);
		pulse(src_of(19, 1'b0), 1'b0);
		repeat (8) @(negedge mclk_in);
		chk(16'(irq), 16'h0000);
		give_back();
		repeat (6) @(negedge mclk_in);
		chk(16'(irq), 16'h0000);
		give_back();
		offer(ev(19), 1'b0);
		give_back();
		@(posedge mclk_in);
		prio <= '0;
		$display("test nest done");
	endtask : t_nest
	task t_mask;
		@(posedge mclk_in);
		mask <= 22'h00_0004;
		pulse(src_of(2, 1'b0), 1'b0);
		repeat (6) @(negedge mclk_in);
		chk(16'(pend[2]), 16'h0001);
		chk(16'({stby, irq}), 16'h0000);
		@(posedge mclk_in);
		mask <= '0;
		repeat (2) @(negedge mclk_in);
		chk(16'(stby), 16'h0001);
		offer(ev(2), 1'b0);
		give_back();
		// Masking an offered request withdraws it but keeps it pending
		@(posedge mclk_in);
		lag <= 4'h9;
		pulse(src_of(4, 1'b0), 1'b0);
		repeat (2) @(negedge mclk_in);
		chk(16'(irq), 16'h0001);
		@(posedge mclk_in);
		mask <= 22'h00_0010;
		repeat (2) @(negedge mclk_in);
		chk(16'({irq, pend[4]}), 16'h0001);
		@(posedge mclk_in);
		mask <= '0;
		offer(ev(4), 1'b0);
		give_back();
		lag <= 4'h0;
		$display("test mask done");
	endtask : t_mask
	task t_break;
		@(posedge mclk_in);
		enable <= 1'b0;
		pulse(src_of(0, 1'b0), 1'b0);
		pulse('0, 1'b1);
		offer(16'h003E, 1'b1);
		chk(16'({ish, isl}), 16'h0000);
		@(posedge mclk_in);
		enable <= 1'b1;
		offer(ev(0), 1'b0);
		give_back();
		$display("test break done");
	endtask : t_break
	task t_reset;
		for (int r = 0; r < 4; r++) begin
			@(posedge mclk_in);
			rsrc <= 4'(1 << r);
			repeat (2) @(negedge mclk_in);
			chk({15'h0000, rreq}, 16'h0001);
			chk(vec, 16'h0000);
			@(posedge mclk_in);
			rsrc <= '0;
		end
		$display("test reset done");
	endtask : t_reset
	initial begin
		repeat (16) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_table();
		t_order();
		t_nest();
		t_mask();
		t_break();
		t_reset();
		summarize();
	end
endmodule : vectored_interrupt_control_bench
